// *** eeprom_pkg.sv ***
// Function
// - 128-byte record, sixteen 512-byte main pages
// - Record erase sets ones, internal only
// - No host command erases record block
// - Code 0xD4 erases page 4 to 15
// - Erase of page 0 or 1 refused
// - Page erase only while unlocked
// - Whole-page erase; byte writes only clear bits
// - Code 0xF1 reads record bytes
// - Code 0xD3 sets start offset in page
// - Record read returns at most 128 bytes
// - Locked reads of pages 0, 1 meaningless
// - Pages 2 to 15 always readable
// - Codes 0xB0 to 0xBF move page data
// - Main read returns at most 256 bytes
// - Main writes accept up to 256 bytes
// - No host write path into record
// - Writes to pages 0, 1 are refused
// - Start-up copies user settings to registers
// - Two correct passwords via 0xD5 unlock
// - Wrong password locks memory
package eeprom_pkg;
    localparam int         REC_BYTES   = 128;
    localparam int         PAGE_BYTES  = 512;
    localparam int         NUM_PAGES   = 16;
    localparam int         MAX_XFER    = 256;
    localparam logic [7:0] CMD_RD_LEN  = 8'hD2;
    localparam logic [7:0] CMD_OFFSET  = 8'hD3;
    localparam logic [7:0] CMD_ERASE   = 8'hD4;
    localparam logic [7:0] CMD_PWD     = 8'hD5;
    localparam logic [7:0] CMD_REC_RD  = 8'hF1;
    localparam logic [3:0] CMD_PAGE_HI = 4'hB;
    localparam logic [7:0] PWD_VALUE   = 8'hFF;
    localparam logic [7:0] ERASED      = 8'hFF;
    localparam logic [7:0] OVERRUN     = 8'hFF;
    localparam logic [7:0] HIDDEN      = 8'h00;
    localparam logic [3:0] USER_PAGE   = 4'h1;
    localparam logic [3:0] FIRST_OPEN  = 4'h2;
    localparam logic [3:0] FIRST_FREE  = 4'h4;
    localparam logic [8:0] NRD_RESET   = 9'h001;
    localparam logic [8:0] OFF_RESET   = 9'h000;
    localparam int         CLK_HZ      = 40_000_000;
    localparam int         ERASE_MS    = 35;
    localparam int         TIMEOUT_MS  = 25;
    localparam int         PROG_US     = 20;
    localparam int         ERASE_CYC   = ERASE_MS * (CLK_HZ / 1000);
    localparam int         TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int         PROG_CYC    = PROG_US * (CLK_HZ / 1000000);
    localparam int         FIFO_WIDTH  = 8;
    localparam int         FIFO_DEPTH  = 8;
    localparam int         CNT_W       = 21;

    typedef enum logic [2:0] {
        S_BOOT, S_IDLE, S_ERASE, S_PROG, S_REC_ERASE, S_REC_PROG
    } st_t;
endpackage

// *** sync_fifo.sv ***
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = cnt_q != (AW + 1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Depth is a power of two so the pointers wrap by overflow
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

// *** eeprom_access_controller.sv ***
`timescale 1ns/1ps
module eeprom_access_controller
    import eeprom_pkg::*;
#(
    parameter int ERASE_CYCLES   = ERASE_CYC,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        scl_in,
    input  wire logic        txn_start,
    input  wire logic [7:0]  txn_code,
    input  wire logic        txn_read,
    input  wire logic        txn_end,
    output logic             cmd_ready,
    input  wire logic        wr_valid,
    input  wire logic [7:0]  wr_data,
    output logic             wr_ready,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    input  wire logic        rd_ready,
    output logic             txn_nack,
    output logic             unlocked,
    input  wire logic        ff_save,
    input  wire logic [15:0] ff_data,
    output logic             cfg_valid,
    output logic [8:0]       cfg_addr,
    output logic [7:0]       cfg_data,
    output logic             cfg_done
);
    logic [7:0]       main_q [NUM_PAGES * PAGE_BYTES];
    logic [7:0]       rec_q [REC_BYTES];
    st_t              state_q;
    logic [CNT_W-1:0] wait_q;
    logic [CNT_W-1:0] low_q;
    logic [7:0]       code_q;
    logic             rd_txn_q;
    logic             active_q;
    logic [8:0]       bcnt_q;
    logic [8:0]       rcnt_q;
    logic [8:0]       off_q;
    logic [8:0]       nrd_q;
    logic [3:0]       pg_q;
    logic [8:0]       pa_q;
    logic [7:0]       pd_q;
    logic             hit_q;
    logic             unlocked_q;
    logic             nack_q;
    logic             ff_pend_q;
    logic [15:0]      ff_q;
    logic [8:0]       boot_q;
    logic             scl_m_q;
    logic             scl_s_q;
    logic             rd_valid_q;
    logic [7:0]       rd_data_q;
    logic             cfg_valid_q;
    logic [8:0]       cfg_addr_q;
    logic [7:0]       cfg_data_q;
    logic             cfg_done_q;
    logic             f_valid;
    logic             f_ready;
    logic [7:0]       f_data;
    logic             pop;
    logic             accept;
    logic             timeout;
    logic             is_page;
    logic [3:0]       cpg;
    logic             wr_pop;
    logic             rd_load;
    logic [8:0]       raddr;
    logic [8:0]       lim;
    logic [7:0]       rd_d;

    sync_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   (wr_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign cpg       = code_q[3:0];
    assign is_page   = code_q[7:4] == CMD_PAGE_HI;
    // Busy states stop both the byte drain and new commands
    assign f_ready   = state_q == S_IDLE && !ff_pend_q;
    assign cmd_ready = f_ready && !f_valid;
    assign pop       = f_valid && f_ready;
    assign wr_pop    = pop && active_q && !rd_txn_q;
    assign accept    = txn_start && cmd_ready;
    assign timeout   = low_q == CNT_W'(TIMEOUT_CYCLES - 1);
    assign rd_valid  = rd_valid_q;
    assign rd_data   = rd_data_q;
    assign txn_nack  = nack_q;
    assign unlocked  = unlocked_q;
    assign cfg_valid = cfg_valid_q;
    assign cfg_addr  = cfg_addr_q;
    assign cfg_data  = cfg_data_q;
    assign cfg_done  = cfg_done_q;

    // A stuck-low link clock aborts the transaction in progress
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            low_q   <= '0;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            if (scl_s_q || timeout) begin
                low_q <= '0;
            end else begin
                low_q <= low_q + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= S_BOOT;
            wait_q   <= '0;
            code_q   <= '0;
            rd_txn_q <= 1'b0;
            active_q <= 1'b0;
            bcnt_q   <= '0;
            nack_q   <= 1'b0;
            pg_q     <= '0;
            pa_q     <= '0;
            pd_q     <= '0;
        end else begin
            if (accept) begin
                active_q <= 1'b1;
                code_q   <= txn_code;
                rd_txn_q <= txn_read;
                bcnt_q   <= '0;
                nack_q   <= 1'b0;
            end else if (txn_end || timeout) begin
                active_q <= 1'b0;
            end
            case (state_q)
                S_BOOT: begin
                    if (boot_q == 9'(PAGE_BYTES - 1)) begin
                        state_q <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (ff_pend_q) begin
                        state_q <= S_REC_ERASE;
                        wait_q  <= CNT_W'(ERASE_CYCLES - 1);
                    end else if (wr_pop) begin
                        if (bcnt_q != 9'h1FF) begin
                            bcnt_q <= bcnt_q + 9'h001;
                        end
                        if (code_q == CMD_ERASE && bcnt_q == '0 &&
                            unlocked_q && f_data[7:4] == 4'h0 &&
                            f_data[3:0] >= FIRST_FREE) begin
                            state_q <= S_ERASE;
                            pg_q    <= f_data[3:0];
                            wait_q  <= CNT_W'(ERASE_CYCLES - 1);
                        end else if (is_page && unlocked_q &&
                                     cpg >= FIRST_OPEN &&
                                     bcnt_q < 9'(MAX_XFER)) begin
                            state_q <= S_PROG;
                            pg_q    <= cpg;
                            pa_q    <= off_q + bcnt_q;
                            pd_q    <= f_data;
                            wait_q  <= CNT_W'(PROG_CYC - 1);
                        end else if (!(code_q == CMD_RD_LEN && bcnt_q == '0) &&
                                     !(code_q == CMD_OFFSET && bcnt_q < 9'h002)
                                     && !(code_q == CMD_PWD && bcnt_q == '0))
                        begin
                            // Refused erase, record write, overflow
                            nack_q <= 1'b1;
                        end
                    end
                end
                S_ERASE, S_PROG, S_REC_ERASE, S_REC_PROG: begin
                    if (wait_q != '0) begin
                        wait_q <= wait_q - 1'b1;
                    end else if (state_q == S_REC_ERASE) begin
                        state_q <= S_REC_PROG;
                        wait_q  <= CNT_W'(PROG_CYC - 1);
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Nonvolatile contents have no reset; the array stands in for the cells
    always_ff @(posedge ref_clk) begin
        if (state_q == S_ERASE && wait_q == '0) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                main_q[{pg_q, 9'(i)}] <= ERASED;
            end
        end
        if (state_q == S_PROG && wait_q == '0) begin
            main_q[{pg_q, pa_q}] <= main_q[{pg_q, pa_q}] & pd_q;
        end
        if (state_q == S_REC_ERASE && wait_q == '0) begin
            for (int i = 0; i < REC_BYTES; i++) begin
                rec_q[i] <= ERASED;
            end
        end
        if (state_q == S_REC_PROG && wait_q == '0) begin
            rec_q[0] <= ff_q[15:8];
            rec_q[1] <= ff_q[7:0];
        end
    end

    // Set wins over the clear taken when the save starts
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ff_pend_q <= 1'b0;
            ff_q      <= '0;
        end else if (ff_save) begin
            ff_pend_q <= 1'b1;
            ff_q      <= ff_data;
        end else if (state_q == S_IDLE) begin
            ff_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hit_q      <= 1'b0;
            unlocked_q <= 1'b0;
        end else if (wr_pop && code_q == CMD_PWD && bcnt_q == '0) begin
            if (f_data == PWD_VALUE) begin
                unlocked_q <= unlocked_q || hit_q;
                hit_q      <= !hit_q;
            end else begin
                unlocked_q <= 1'b0;
                hit_q      <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            nrd_q <= NRD_RESET;
            off_q <= OFF_RESET;
        end else if (wr_pop && code_q == CMD_RD_LEN && bcnt_q == '0) begin
            // Zero selects the full 256-byte transfer
            nrd_q <= (f_data == '0) ? 9'(MAX_XFER) : {1'b0, f_data};
        end else if (wr_pop && code_q == CMD_OFFSET && bcnt_q == '0) begin
            off_q[8] <= f_data[0];
        end else if (wr_pop && code_q == CMD_OFFSET && bcnt_q == 9'h001) begin
            off_q[7:0] <= f_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_q      <= '0;
            cfg_valid_q <= 1'b0;
            cfg_addr_q  <= '0;
            cfg_data_q  <= '0;
            cfg_done_q  <= 1'b0;
        end else begin
            cfg_valid_q <= state_q == S_BOOT;
            if (state_q == S_BOOT) begin
                cfg_addr_q <= boot_q;
                cfg_data_q <= main_q[{USER_PAGE, boot_q}];
                boot_q     <= boot_q + 9'h001;
            end
            if (state_q == S_BOOT && boot_q == 9'(PAGE_BYTES - 1)) begin
                cfg_done_q <= 1'b1;
            end
        end
    end

    assign rd_load = active_q && rd_txn_q && state_q == S_IDLE &&
                     (!rd_valid_q || rd_ready);
    assign raddr   = off_q + rcnt_q;

    always_comb begin
        lim  = '0;
        rd_d = OVERRUN;
        if (code_q == CMD_REC_RD) begin
            lim = (nrd_q > 9'(REC_BYTES)) ? 9'(REC_BYTES) : nrd_q;
        end else if (is_page) begin
            lim = nrd_q;
        end
        if (rcnt_q >= lim) begin
            rd_d = OVERRUN;
        end else if (code_q == CMD_REC_RD) begin
            rd_d = rec_q[raddr[6:0]];
        end else if (cpg < FIRST_OPEN && !unlocked_q) begin
            rd_d = HIDDEN;
        end else begin
            rd_d = main_q[{cpg, raddr}];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= '0;
            rcnt_q     <= '0;
        end else if (accept || !active_q) begin
            rd_valid_q <= 1'b0;
            rcnt_q     <= '0;
        end else if (rd_load) begin
            rd_valid_q <= 1'b1;
            rd_data_q  <= rd_d;
            if (rcnt_q != 9'h1FF) begin
                rcnt_q <= rcnt_q + 9'h001;
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_erase_guard: assert property (wr_pop && code_q == CMD_ERASE &&
        bcnt_q == '0 && f_data < 8'h04 |=> state_q == S_IDLE && nack_q)
        else $error("erase of protected page was not refused");
    a_erase_lock: assert property (state_q == S_ERASE &&
        $past(state_q) == S_IDLE |-> $past(unlocked_q))
        else $error("page erase started while locked");
    a_erase_ones: assert property (state_q == S_ERASE &&
        wait_q == '0 |=> main_q[{pg_q, 9'h1FF}] == ERASED)
        else $error("erased page byte not all ones");
    a_prog_clear: assert property (state_q == S_PROG &&
        wait_q == '0 |=> (main_q[{$past(pg_q), $past(pa_q)}] &
        ~$past(pd_q)) == 8'h00)
        else $error("byte program set a bit");
    a_page01_wr: assert property (wr_pop && is_page &&
        cpg < FIRST_OPEN |=> nack_q && state_q == S_IDLE)
        else $error("write to page 0 or 1 accepted");
    a_rd_limit: assert property (rd_load && !accept &&
        rcnt_q >= nrd_q |=> rd_data_q == OVERRUN)
        else $error("byte read past the length limit");
    a_locked_rd: assert property (rd_load && !accept && is_page &&
        cpg < FIRST_OPEN && !unlocked_q && rcnt_q < nrd_q
        |=> rd_data_q == HIDDEN)
        else $error("protected page readable while locked");
    a_unlock_two: assert property (wr_pop && code_q == CMD_PWD &&
        bcnt_q == '0 && f_data == PWD_VALUE && hit_q |=> unlocked_q)
        else $error("two correct passwords did not unlock");
    a_lock_wrong: assert property (wr_pop && code_q == CMD_PWD &&
        bcnt_q == '0 && f_data != PWD_VALUE |=> !unlocked_q)
        else $error("wrong password did not lock");
    a_busy_hold: assert property (state_q != S_IDLE && wait_q != '0 |=>
        state_q == $past(state_q) && !pop && !cmd_ready)
        else $error("new operation taken while busy");
    a_boot_done: assert property ($rose(cfg_done_q) |->
        $past(cfg_addr_q) == 9'h1FE && cfg_addr_q == 9'h1FF)
        else $error("user settings upload incomplete");

    c_erase: cover property (state_q == S_ERASE ##1 state_q == S_ERASE);
    c_prog: cover property (state_q == S_PROG && wait_q == '0);
    c_rec_rd: cover property (rd_load && code_q == CMD_REC_RD);
    c_fifo_full: cover property (!wr_ready && state_q == S_PROG);
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
module host_model (
    input  wire logic       ref_clk,
    input  wire logic       cmd_ready,
    input  wire logic       wr_ready,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            scl_in,
    output logic            txn_start,
    output logic [7:0]      txn_code,
    output logic            txn_read,
    output logic            txn_end,
    output logic            wr_valid,
    output logic [7:0]      wr_data,
    output logic            rd_ready,
    output logic            hang
);
    logic in_frame;
    int   waited;

    initial begin
        {scl_in, rd_ready} = 2'b11;
        {txn_start, txn_read, txn_end, wr_valid, hang, in_frame} = '0;
        txn_code = 8'h00;
        wr_data  = 8'h00;
    end

    // Link clock only toggles inside a frame; idles high on its pull-up
    always #100 scl_in = in_frame ? ~scl_in : 1'b1;

    function automatic logic pick(input int w);
        return w == 0 ? cmd_ready : w == 1 ? wr_ready : rd_valid;
    endfunction

    // Polled at the falling edge so the answer has settled
    task automatic wait_hi(input int w, input int limit);
        waited = 0;
        do begin
            @(negedge ref_clk);
            waited++;
        end while (pick(w) !== 1'b1 && waited < limit);
        if (pick(w) !== 1'b1) hang = 1'b1;
    endtask

    task automatic begin_txn(input logic [7:0] code, input logic rd);
        @(posedge ref_clk);
        in_frame  <= 1'b1;
        txn_start <= 1'b1;
        txn_code  <= code;
        txn_read  <= rd;
        wait_hi(0, 4000);
        @(posedge ref_clk);
        txn_start <= 1'b0;
    endtask

    task automatic push(input logic [7:0] d);
        @(posedge ref_clk);
        wr_valid <= 1'b1;
        wr_data  <= d;
        wait_hi(1, 100);
    endtask

    task automatic end_txn();
        @(posedge ref_clk);
        txn_end <= 1'b1;
        @(posedge ref_clk);
        txn_end  <= 1'b0;
        in_frame <= 1'b0;
    endtask

    // Ending before the queue drains could drop bytes, so wait first
    task automatic finish();
        @(posedge ref_clk);
        wr_valid <= 1'b0;
        wait_hi(0, 4000);
        end_txn();
    endtask

    task automatic rd_byte(input logic slow, output logic [7:0] got);
        // Called on the edge that took the last byte, so lower at once
        if (slow) begin
            rd_ready <= 1'b0;
            repeat (2) @(posedge ref_clk);
            rd_ready <= 1'b1;
        end
        wait_hi(2, 100);
        got = rd_data;
        @(posedge ref_clk);
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
    import eeprom_pkg::*;
;
    localparam int ERASE_P = 600;
    logic        ref_clk, rst_b, ff_save, hang, scl_in, txn_start, txn_read;
    logic        txn_end, cmd_ready, wr_valid, wr_ready, rd_valid, rd_ready;
    logic        txn_nack, unlocked, cfg_valid, cfg_done;
    logic [7:0]  txn_code, wr_data, rd_data, cfg_data, r;
    logic [8:0]  cfg_addr;
    logic [15:0] ff_data;
    logic [7:0]  b[3];
    logic [7:0]  q[$];
    int          err_count, num_checks, cfg_seen;

    eeprom_access_controller #(
        .ERASE_CYCLES  (ERASE_P),
        .TIMEOUT_CYCLES(2000)
    ) i_eeprom_access_controller (
        .ref_clk, .rst_b, .scl_in, .txn_start, .txn_code, .txn_read,
        .txn_end, .cmd_ready, .wr_valid, .wr_data, .wr_ready, .rd_valid,
        .rd_data, .rd_ready, .txn_nack, .unlocked, .ff_save, .ff_data,
        .cfg_valid, .cfg_addr, .cfg_data, .cfg_done
    );

    host_model i_host_model (
        .ref_clk, .cmd_ready, .wr_ready, .rd_valid, .rd_data, .scl_in,
        .txn_start, .txn_code, .txn_read, .txn_end, .wr_valid, .wr_data,
        .rd_ready, .hang
    );

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) cfg_seen <= 0;
        else if (cfg_valid) cfg_seen <= cfg_seen + 1;
    end

    always @(posedge hang) begin
        err_count++;
        conclude();
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    task automatic wcmd(input logic [7:0] code, input logic [7:0] d[$],
                        input logic nack);
        i_host_model.begin_txn(code, 1'b0);
        foreach (d[k]) i_host_model.push(d[k]);
        i_host_model.finish();
        @(negedge ref_clk);
        check("txn_nack", 16'(nack), 16'(txn_nack));
    endtask

    task automatic setrd(input logic [7:0] len, input logic [8:0] off);
        wcmd(CMD_RD_LEN, '{len}, 1'b0);
        wcmd(CMD_OFFSET, '{{7'h00, off[8]}, off[7:0]}, 1'b0);
    endtask

    task automatic rdcmd(input logic [7:0] code, input int n,
                         input logic slow);
        logic [7:0] got;
        q = {};
        i_host_model.begin_txn(code, 1'b1);
        repeat (n) begin
            i_host_model.rd_byte(slow, got);
            q.push_back(got);
        end
        i_host_model.end_txn();
    endtask

    initial begin
        void'($urandom(80294));
        {rst_b, ff_save, err_count, num_checks} = '0;
        ff_data = 16'h0000;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2000) if (cfg_done !== 1'b1) @(negedge ref_clk);
        // The last upload pulse is counted one edge after done rises
        @(negedge ref_clk);
        check("upload done", 16'h0001, 16'(cfg_done));
        check("upload bytes", 16'(PAGE_BYTES), 16'(cfg_seen));
        check("upload last", 16'h01FF, 16'(cfg_addr));
        wcmd(CMD_ERASE, '{8'h04}, 1'b1);
        wcmd({CMD_PAGE_HI, 4'h5}, '{8'h00}, 1'b1);
        wcmd(CMD_PWD, '{PWD_VALUE}, 1'b0);
        wcmd(CMD_PWD, '{PWD_VALUE}, 1'b0);
        check("unlocked", 16'h0001, 16'(unlocked));
        for (int p = 0; p < 4; p++) wcmd(CMD_ERASE, '{p[7:0]}, 1'b1);
        wcmd(CMD_ERASE, '{8'h04}, 1'b0);
        // Controller must stay busy for the whole erase before the next one
        check("erase busy", 16'h0001, 16'(i_host_model.waited >= ERASE_P));
        foreach (b[k]) b[k] = 8'($urandom) & 8'h7F;
        r = 8'($urandom);
        setrd(8'h03, 9'h000);
        wcmd({CMD_PAGE_HI, 4'h4}, '{b[0], b[1], b[2]}, 1'b0);
        wcmd({CMD_PAGE_HI, 4'h4}, '{r}, 1'b0);
        rdcmd({CMD_PAGE_HI, 4'h4}, 3, 1'b1);
        check("page4 b0", 16'(b[0] & r), 16'(q[0]));
        for (int k = 1; k < 3; k++) check("page4 bn", 16'(b[k]), 16'(q[k]));
        wcmd({CMD_PAGE_HI, 4'h1}, '{8'h00}, 1'b1);
        wcmd({CMD_PAGE_HI, 4'h0}, '{8'h00}, 1'b1);
        setrd(8'h00, 9'h100);
        rdcmd({CMD_PAGE_HI, 4'h4}, 257, 1'b0);
        check("erased byte", 16'(ERASED), 16'(q[0]));
        check("overrun byte", 16'(OVERRUN), 16'(q[256]));
        wcmd(CMD_PWD, '{8'h5A}, 1'b0);
        check("unlocked", 16'h0000, 16'(unlocked));
        setrd(8'h01, 9'h000);
        rdcmd({CMD_PAGE_HI, 4'h4}, 1, 1'b0);
        check("locked page4", 16'(b[0] & r), 16'(q[0]));
        rdcmd({CMD_PAGE_HI, 4'h1}, 1, 1'b0);
        check("locked page1", 16'(HIDDEN), 16'(q[0]));
        wcmd(CMD_REC_RD, '{8'h00}, 1'b1);
        @(posedge ref_clk);
        ff_save <= 1'b1;
        ff_data <= 16'($urandom) & 16'h7F7F;
        @(posedge ref_clk);
        ff_save <= 1'b0;
        setrd(8'h00, 9'h000);
        rdcmd(CMD_REC_RD, 129, 1'b0);
        check("record hi", 16'(ff_data[15:8]), 16'(q[0]));
        check("record lo", 16'(ff_data[7:0]), 16'(q[1]));
        check("record erased", 16'(ERASED), 16'(q[2]));
        check("record overrun", 16'(OVERRUN), 16'(q[128]));
        conclude();
    end
endmodule
